/* psm_cmds.sv */
// Contract
// - Clear resets status flags of unpaged and selected pages
// - Clear also releases alert output
// - Clear never restarts a latched-off channel
// - Persisting fault sets flag and alert again
// - Global page clears all channels
// - Store copies operating words to user memory
// - Restore on command and after reset
// - Report busy during store or restore
// - Supervision suspended during restore; host avoids
// - Feature byte fixed 0xB0, read-only
// - Output exponent byte fixed 0x13, read-only
// - Output voltage words are 16-bit
// - Odd current channel refuses voltage limits
// - Input voltage words are 16-bit
// - Temperature limit words are 16-bit
// - On-delay counts on share clock only
// - Rise time counts share or oscillator
// - Unmask on UV reached, else timeout fault
// - Zero maximum on time disables limit
// - Off-delay counts share or oscillator
// - On/off delay clamp 13.1 s, rounding
// - Rise/max clamp 655 ms; read raw
`timescale 1ns/100ps
`default_nettype none
module psm_cmds
  import psm_pkg::*;
(
  input wire logic clk,                          // Core clock
  input wire logic rst,                          // Core reset
  input wire logic link_clk,                     // Serial engine clock
  input wire logic link_rst,                     // Serial engine reset
  input wire logic link_req_valid,               // Decoded command present
  input wire psm_pkg::psm_req_t link_req,        // Decoded command
  output logic link_req_ready,                   // Command may be offered
  output logic link_rsp_valid,                   // Answer pulse
  output psm_pkg::psm_rsp_t link_rsp,            // Answer
  output logic link_busy,                        // Memory transfer running
  input wire logic [psm_pkg::NCH-1:0] channel_on_pin, // Control pins
  input wire logic [psm_pkg::NCH-1:0] op_on,     // Serial on command per channel
  input wire logic share_clk,                    // Shared sequencing clock pin
  input wire logic share_present,                // Shared clock available
  input wire logic [psm_pkg::NCH-1:0] cur_mode,  // Channel measures current
  input wire logic [psm_pkg::NCH-1:0] uv_reached, // Output above UV fault limit
  input wire logic [psm_pkg::NCH-1:0][6:0] chan_fault, // Paged fault conditions
  input wire logic [7:0] unpaged_fault,          // Input and temperature conditions
  output logic [psm_pkg::NCH-1:0] conv_en,       // Converter enables
  output logic [psm_pkg::NCH-1:0] dac_link,      // DAC soft-connected
  output logic [psm_pkg::NCH-1:0] uv_unmask,     // UV threshold armed
  output logic host_alert_n_o,                   // Alert drive level
  output logic host_alert_n_oe,                  // Alert pulled low
  output logic supervise_hold,                   // Supervision suspended
  output logic nv_busy                           // Store or restore running
);
  import psm_pkg::*;

  // ****************************************
  // Link domain
  // ****************************************
  typedef struct packed {
    logic pend;
    logic rdy;
    psm_req_t req;
    logic req_tgl;
    logic ak_s1, ak_s2, ak_s3;
    logic rsp_vld;
    psm_rsp_t rsp;
    logic bz_s1, bz_s2;
  } psm_link_t;

  typedef struct packed {
    logic rq_s1, rq_s2, rq_s3;
    logic ack_tgl;
    psm_rsp_t rsp;
    logic sh_s1, sh_s2, sh_s3, pr_s1, pr_s2;
    logic [NCH-1:0] pin_s1, pin_s2;
    logic [11:0] osc_cnt;
    logic [7:0] page;
    logic [NCH-1:0][NPW-1:0][15:0] pw, nvp;
    logic [NUW-1:0][15:0] uw, nvu;
    psm_nv_t nv;
    logic [7:0] nv_cnt;
    logic [NCH-1:0][7:0] stat;
    logic [7:0] ustat;
    logic alert;
    logic alert_lvl;
    psm_seq_t [NCH-1:0] seq;
    logic [NCH-1:0][20:0] cnt, mcnt;
    logic [NCH-1:0] conv_en, dac_link, uv_unmask;
    logic busy, hold;
  } psm_core_t;

  psm_link_t l_r, l_nxt;
  psm_core_t c_r, c_nxt;

  always_comb begin
    l_nxt = l_r;
    l_nxt.ak_s1 = c_r.ack_tgl;
    l_nxt.ak_s2 = l_r.ak_s1;
    l_nxt.ak_s3 = l_r.ak_s2;
    l_nxt.bz_s1 = c_r.busy;
    l_nxt.bz_s2 = l_r.bz_s1;
    l_nxt.rsp_vld = 1'b0;
    // Answer settles in the core on the same edge as its toggle, well before the synchronised toggle is seen
    if (l_r.ak_s2 != l_r.ak_s3) begin
      l_nxt.rsp = c_r.rsp;
      l_nxt.rsp_vld = 1'b1;
      l_nxt.pend = 1'b0;
    end else if (link_req_valid && !l_r.pend) begin
      l_nxt.req = link_req;
      l_nxt.req_tgl = ~l_r.req_tgl;
      l_nxt.pend = 1'b1;
    end
    l_nxt.rdy = ~l_nxt.pend;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      l_r <= '0;
      l_r.rdy <= 1'b1;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  // L11 milliseconds to 10 us ticks, clamped, optional coarse rounding
  function automatic logic [20:0] l11_ticks(input logic [15:0] w, input logic coarse, input logic [20:0] lim);
    logic [4:0] e;
    logic [4:0] s;
    logic [31:0] p;
    logic [31:0] v;
    e = w[15:11];
    s = 5'(~e + 5'h01);
    p = 32'(w[10:0]) * 32'h00000064;
    if (w[10]) begin
      v = 32'h00000000;
    end else if (!e[4]) begin
      v = (e > 5'h08) ? 32'hFFFFFFFF : (p << e);
    end else begin
      v = (p + ((32'h00000001 << s) >> 1)) >> s;
    end
    if (v > 32'(lim)) begin
      v = 32'(lim);
    end
    if (coarse && v > 32'(RISE_CLAMP_TICKS)) begin
      v = ((v + (COARSE_STEP >> 1)) / COARSE_STEP) * COARSE_STEP;
    end
    return v[20:0];
  endfunction

  function automatic logic is_vlim(input logic [3:0] idx);
    return (idx == PW_OVF) || (idx == PW_OVW) || (idx == PW_UVW) || (idx == PW_UVF);
  endfunction

  // ****************************************
  // Core domain
  // ****************************************
  logic go;
  logic pg_all, pg_one;
  logic [2:0] pch;
  logic tick_sh, tick_osc, tick_any;
  logic p_hit, u_hit;
  logic [3:0] p_idx, u_idx;
  logic clr;
  logic [NCH-1:0] clr_ch;
  logic [NCH-1:0] tonmax_evt;
  logic [7:0] cond;
  logic new_evt;
  logic req;

  always_comb begin
    c_nxt = c_r;
    p_hit = 1'b0;
    u_hit = 1'b0;
    p_idx = 4'h0;
    u_idx = 4'h0;
    clr = 1'b0;
    clr_ch = '0;
    tonmax_evt = '0;
    cond = 8'h00;
    new_evt = 1'b0;
    req = 1'b0;
    go = c_r.rq_s2 ^ c_r.rq_s3;
    pg_all = c_r.page == PAGE_ALL;
    pg_one = c_r.page < 8'(NCH);
    pch = c_r.page[2:0];

    // Synchronisers and tick sources
    c_nxt.rq_s1 = l_r.req_tgl;
    c_nxt.rq_s2 = c_r.rq_s1;
    c_nxt.rq_s3 = c_r.rq_s2;
    c_nxt.sh_s1 = share_clk;
    c_nxt.sh_s2 = c_r.sh_s1;
    c_nxt.sh_s3 = c_r.sh_s2;
    c_nxt.pr_s1 = share_present;
    c_nxt.pr_s2 = c_r.pr_s1;
    c_nxt.pin_s1 = channel_on_pin;
    c_nxt.pin_s2 = c_r.pin_s1;
    tick_sh = c_r.sh_s2 & ~c_r.sh_s3;
    tick_osc = c_r.osc_cnt == 12'(TICK_CYC - 1);
    c_nxt.osc_cnt = tick_osc ? 12'h000 : c_r.osc_cnt + 12'h001;
    tick_any = c_r.pr_s2 ? tick_sh : tick_osc;

    for (int k = 0; k < NPW; k++) begin
      if (c_r.rq_s3 != c_r.rq_s2 && l_r.req.cmd == PW_CODE[k]) begin
        p_hit = 1'b1;
        p_idx = 4'(k);
      end
    end
    for (int k = 0; k < NUW; k++) begin
      if (l_r.req.cmd == UW_CODE[k]) begin
        u_hit = 1'b1;
        u_idx = 4'(k);
      end
    end

    // ****************************************
    // Command execution
    // ****************************************
    if (go) begin
      c_nxt.ack_tgl = ~c_r.ack_tgl;
      c_nxt.rsp = '0;
      c_nxt.rsp.busy = c_r.busy;
      if (c_r.busy) begin
        c_nxt.rsp.err = 1'b1;
      end else if (l_r.req.cmd == CMD_PAGE) begin
        if (l_r.req.wr) begin
          c_nxt.page = l_r.req.wdata[7:0];
        end else begin
          c_nxt.rsp.rdata = {8'h00, c_r.page};
        end
      end else if (l_r.req.cmd == CMD_CLEAR) begin
        clr = 1'b1;
      end else if (l_r.req.cmd == CMD_STORE) begin
        c_nxt.nv = NV_STORE;
        c_nxt.nv_cnt = 8'h00;
        c_nxt.busy = 1'b1;
      end else if (l_r.req.cmd == CMD_RESTORE) begin
        c_nxt.nv = NV_RESTORE;
        c_nxt.nv_cnt = 8'h00;
        c_nxt.busy = 1'b1;
      end else if (l_r.req.cmd == CMD_FEATURE) begin
        c_nxt.rsp.rdata = {8'h00, FEATURE_VAL};
        c_nxt.rsp.err = l_r.req.wr;
      end else if (l_r.req.cmd == CMD_VEXP) begin
        c_nxt.rsp.rdata = {8'h00, VEXP_VAL};
        c_nxt.rsp.err = l_r.req.wr;
      end else if (l_r.req.cmd == CMD_STATUS) begin
        c_nxt.rsp.rdata = {8'h00, pg_one ? c_r.stat[pch] : c_r.ustat};
        c_nxt.rsp.err = l_r.req.wr;
      end else if (p_hit) begin
        // Global page writes every channel except refused voltage limits, but cannot be read
        if (l_r.req.wr) begin
          for (int i = 0; i < NCH; i++) begin
            if ((pg_all || (pg_one && pch == 3'(i))) && !(i % 2 == 1 && cur_mode[i] && is_vlim(p_idx))) begin
              c_nxt.pw[i][p_idx] = l_r.req.wdata;
            end
          end
          c_nxt.rsp.err = !(pg_all || pg_one) || (pg_one && pch[0] && cur_mode[pch] && is_vlim(p_idx));
        end else if (pg_one && !(pch[0] && cur_mode[pch] && is_vlim(p_idx))) begin
          c_nxt.rsp.rdata = c_r.pw[pch][p_idx];
        end else begin
          c_nxt.rsp.err = 1'b1;
        end
      end else if (u_hit) begin
        if (l_r.req.wr) begin
          c_nxt.uw[u_idx] = l_r.req.wdata;
        end else begin
          c_nxt.rsp.rdata = c_r.uw[u_idx];
        end
      end else begin
        c_nxt.rsp.err = 1'b1;
      end
    end

    // ****************************************
    // User memory transfer
    // ****************************************
    if (c_r.nv != NV_IDLE) begin
      c_nxt.nv_cnt = c_r.nv_cnt + 8'h01;
      if (c_r.nv_cnt == 8'(NV_BUSY_CYC - 1)) begin
        if (c_r.nv == NV_STORE) begin
          c_nxt.nvp = c_r.pw;
          c_nxt.nvu = c_r.uw;
        end else begin
          c_nxt.pw = c_r.nvp;
          c_nxt.uw = c_r.nvu;
        end
        c_nxt.nv = NV_IDLE;
        c_nxt.busy = 1'b0;
      end
    end
    c_nxt.hold = c_nxt.nv == NV_RESTORE;

    // ****************************************
    // Sequencing per channel
    // ****************************************
    for (int i = 0; i < NCH; i++) begin
      req = c_r.pin_s2[i] & op_on[i];
      case (c_r.seq[i])
        SEQ_IDLE: begin
          if (req) begin
            c_nxt.seq[i] = SEQ_START;
            c_nxt.cnt[i] = 21'h000000;
          end
        end
        SEQ_START: begin
          if (!req) begin
            c_nxt.seq[i] = SEQ_IDLE;
          end else if (c_r.cnt[i] >= l11_ticks(c_r.pw[i][PW_TDLY], 1'b1, ONOFF_CLAMP_TICKS)) begin
            c_nxt.seq[i] = SEQ_RAMP;
            c_nxt.conv_en[i] = 1'b1;
            c_nxt.cnt[i] = 21'h000000;
            c_nxt.mcnt[i] = 21'h000000;
          end else if (tick_sh) begin
            c_nxt.cnt[i] = c_r.cnt[i] + 21'h000001;
          end
        end
        SEQ_RAMP: begin
          if (c_r.cnt[i] >= l11_ticks(c_r.pw[i][PW_TRISE], 1'b0, RISE_CLAMP_TICKS)) begin
            c_nxt.seq[i] = SEQ_RUN;
            c_nxt.dac_link[i] = 1'b1;
          end else if (tick_any) begin
            c_nxt.cnt[i] = c_r.cnt[i] + 21'h000001;
          end
        end
        SEQ_RUN: begin
        end
        SEQ_STOP: begin
          if (c_r.cnt[i] >= l11_ticks(c_r.pw[i][PW_TOFF], 1'b1, ONOFF_CLAMP_TICKS)) begin
            c_nxt.seq[i] = SEQ_IDLE;
            c_nxt.conv_en[i] = 1'b0;
            c_nxt.dac_link[i] = 1'b0;
            c_nxt.uv_unmask[i] = 1'b0;
          end else if (tick_any) begin
            c_nxt.cnt[i] = c_r.cnt[i] + 21'h000001;
          end
        end
        SEQ_LATCH: begin
          // Only a fresh off command leaves; clearing flags does not
          if (!req) begin
            c_nxt.seq[i] = SEQ_IDLE;
          end
        end
        default: begin
          c_nxt.seq[i] = SEQ_IDLE;
        end
      endcase
      if ((c_r.seq[i] == SEQ_RAMP || c_r.seq[i] == SEQ_RUN) && !req) begin
        c_nxt.seq[i] = SEQ_STOP;
        c_nxt.cnt[i] = 21'h000000;
      end
      // Startup timeout watch
      if ((c_r.seq[i] == SEQ_RAMP || c_r.seq[i] == SEQ_RUN) && req && !c_r.uv_unmask[i] && !c_r.hold) begin
        if (uv_reached[i]) begin
          c_nxt.uv_unmask[i] = 1'b1;
        end else if (c_r.pw[i][PW_TMAX][10:0] != 11'h000 &&
                     c_r.mcnt[i] >= l11_ticks(c_r.pw[i][PW_TMAX], 1'b0, RISE_CLAMP_TICKS)) begin
          tonmax_evt[i] = 1'b1;
          c_nxt.seq[i] = SEQ_LATCH;
          c_nxt.conv_en[i] = 1'b0;
          c_nxt.dac_link[i] = 1'b0;
        end else if (tick_any) begin
          c_nxt.mcnt[i] = c_r.mcnt[i] + 21'h000001;
        end
      end
    end

    // ****************************************
    // Status and alert
    // ****************************************
    // Set beats clear, so a lasting condition re-flags at once
    for (int i = 0; i < NCH; i++) begin
      clr_ch[i] = clr && (pg_all || (pg_one && pch == 3'(i)));
      cond = c_r.hold ? 8'h00 : {chan_fault[i], tonmax_evt[i]};
      c_nxt.stat[i] = (c_r.stat[i] & ~{8{clr_ch[i]}}) | cond;
      new_evt = new_evt | (|(cond & (~c_r.stat[i] | {8{clr_ch[i]}})));
    end
    cond = c_r.hold ? 8'h00 : unpaged_fault;
    c_nxt.ustat = (c_r.ustat & ~{8{clr}}) | cond;
    new_evt = new_evt | (|(cond & (~c_r.ustat | {8{clr}})));
    c_nxt.alert = (c_r.alert & ~clr) | new_evt;
    c_nxt.alert_lvl = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_r <= '0;
      c_r.nvp <= c_r.nvp;
      c_r.nvu <= c_r.nvu;
      c_r.nv <= NV_RESTORE;
      c_r.busy <= 1'b1;
      c_r.hold <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link_req_ready = l_r.rdy;
  assign link_rsp_valid = l_r.rsp_vld;
  assign link_rsp = l_r.rsp;
  assign link_busy = l_r.bz_s2;
  assign conv_en = c_r.conv_en;
  assign dac_link = c_r.dac_link;
  assign uv_unmask = c_r.uv_unmask;
  assign host_alert_n_o = c_r.alert_lvl;
  assign host_alert_n_oe = c_r.alert;
  assign supervise_hold = c_r.hold;
  assign nv_busy = c_r.busy;
endmodule
`default_nettype wire

/* psm_pkg.sv */
package psm_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NCH = 8;
  localparam int NPW = 14;
  localparam int NUW = 10;
  // ****************************************
  // Command codes (published bus protocol)
  // ****************************************
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_STORE = 8'h15;
  localparam logic [7:0] CMD_RESTORE = 8'h16;
  localparam logic [7:0] CMD_FEATURE = 8'h19;
  localparam logic [7:0] CMD_VEXP = 8'h20;
  localparam logic [7:0] CMD_STATUS = 8'h78;
  localparam logic [7:0] PAGE_ALL = 8'hFF;
  // Paged command codes, indexed by paged word slot
  localparam logic [NPW-1:0][7:0] PW_CODE = {8'h64, 8'h62, 8'h61, 8'h60, 8'h5F, 8'h5E, 8'h44, 8'h43,
                                             8'h42, 8'h40, 8'h26, 8'h25, 8'h24, 8'h21};
  // Unpaged: input start/stop, input OV/UV fault/warn, temperature limits
  localparam logic [NUW-1:0][7:0] UW_CODE = {8'h53, 8'h52, 8'h51, 8'h4F, 8'h59, 8'h58, 8'h57, 8'h55,
                                             8'h36, 8'h35};
  // Paged slot indices
  localparam logic [3:0] PW_OVF = 4'h4;
  localparam logic [3:0] PW_OVW = 4'h5;
  localparam logic [3:0] PW_UVW = 4'h6;
  localparam logic [3:0] PW_UVF = 4'h7;
  localparam logic [3:0] PW_TDLY = 4'hA;
  localparam logic [3:0] PW_TRISE = 4'hB;
  localparam logic [3:0] PW_TMAX = 4'hC;
  localparam logic [3:0] PW_TOFF = 4'hD;
  // ****************************************
  // Fixed read-only bytes
  // ****************************************
  localparam logic [7:0] FEATURE_VAL = 8'hB0;
  localparam logic [7:0] VEXP_VAL = 8'h13;
  localparam int STAT_TONMAX = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int FINE_US = 10;
  localparam int COARSE_US = 200;
  localparam int ONOFF_CLAMP_MS = 13100;
  localparam int RISE_CLAMP_MS = 655;
  localparam int TICK_CYC = FINE_US * CLK_MHZ;
  localparam logic [20:0] ONOFF_CLAMP_TICKS = 21'(ONOFF_CLAMP_MS * 1000 / FINE_US);
  localparam logic [20:0] RISE_CLAMP_TICKS = 21'(RISE_CLAMP_MS * 1000 / FINE_US);
  localparam logic [31:0] COARSE_STEP = 32'(COARSE_US / FINE_US);
  localparam int NV_BUSY_CYC = 64;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0, SEQ_START = 3'h1, SEQ_RAMP = 3'h3, SEQ_RUN = 3'h2, SEQ_STOP = 3'h6, SEQ_LATCH = 3'h7
  } psm_seq_t;
  typedef enum logic [1:0] {NV_IDLE = 2'h0, NV_STORE = 2'h1, NV_RESTORE = 2'h3} psm_nv_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic wr;
    logic [15:0] wdata;
  } psm_req_t;
  typedef struct packed {
    logic [15:0] rdata;
    logic err;
    logic busy;
  } psm_rsp_t;
endpackage

/* psm_cmds_chk_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module psm_cmds_chk
  import psm_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Core reset
  input wire logic link_clk, // Link clock
  input wire logic link_rst, // Link reset
  input wire logic link_req_valid, // Offer
  input wire logic link_req_ready, // Ready
  input wire logic link_rsp_valid, // Answer pulse
  input wire psm_pkg::psm_rsp_t link_rsp, // Answer
  input wire logic [psm_pkg::NCH-1:0] conv_en, // Enables
  input wire logic [psm_pkg::NCH-1:0] uv_unmask, // UV armed
  input wire logic host_alert_n_o, // Alert level
  input wire logic host_alert_n_oe, // Alert drive
  input wire logic supervise_hold, // Supervision held
  input wire logic nv_busy // Memory busy
);
  // ****************************************
  // Core domain
  // ****************************************
  alert_level_a: assert property (@(posedge clk) disable iff (rst) host_alert_n_o == 1'b0)
    else $error("alert drive level not low");
  hold_in_nv_a: assert property (@(posedge clk) disable iff (rst) supervise_hold |-> nv_busy)
    else $error("supervision held outside memory transfer");
  boot_restore_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> ##[0:2] (nv_busy && supervise_hold))
    else $error("no reload after reset");
  busy_span_a: assert property (@(posedge clk) disable iff (rst) $rose(nv_busy) |-> nv_busy[*8])
    else $error("memory busy too short");
  unmask_en_a: assert property (@(posedge clk) disable iff (rst) (uv_unmask & ~conv_en) == '0)
    else $error("UV armed on disabled channel");
  // ****************************************
  // Link domain
  // ****************************************
  take_block_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (link_req_valid && link_req_ready) |=> !link_req_ready)
    else $error("ready stayed high after take");
  answer_due_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (link_req_valid && link_req_ready) |-> ##[1:12] link_rsp_valid)
    else $error("no answer in time");
  pulse_once_a: assert property (@(posedge link_clk) disable iff (link_rst)
    link_rsp_valid |=> !link_rsp_valid)
    else $error("answer pulse too long");
  busy_err_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (link_rsp_valid && link_rsp.busy) |-> link_rsp.err)
    else $error("busy answer without error");
  cover property (@(posedge clk) disable iff (rst) $fell(host_alert_n_oe));
  cover property (@(posedge clk) disable iff (rst) $rose(uv_unmask[2]));
  cover property (@(posedge link_clk) disable iff (link_rst) link_rsp_valid && link_rsp.err);
endmodule
bind psm_cmds psm_cmds_chk psm_cmds_chk_i (.clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
  .link_req_valid(link_req_valid), .link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid),
  .link_rsp(link_rsp), .conv_en(conv_en), .uv_unmask(uv_unmask), .host_alert_n_o(host_alert_n_o),
  .host_alert_n_oe(host_alert_n_oe), .supervise_hold(supervise_hold), .nv_busy(nv_busy));
`default_nettype wire

/* psm_host.sv */
`timescale 1ns/100ps
`default_nettype none
module psm_host
  import psm_pkg::*;
(
  input wire logic link_clk, // Link clock
  output logic link_req_valid, // Offer
  output psm_pkg::psm_req_t link_req, // Command
  input wire logic link_req_ready, // Ready
  input wire logic link_rsp_valid, // Answer pulse
  input wire psm_pkg::psm_rsp_t link_rsp // Answer
);
  initial begin
    link_req_valid = 1'b0;
    link_req = '0;
  end
  // One command at a time; held until taken, answer awaited under a bound
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d, output psm_rsp_t r);
    int n;
    r = '0;
    @(negedge link_clk);
    link_req_valid = 1'b1;
    link_req = '{cmd: c, wr: w, wdata: d};
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_req_ready !== 1'b1 && n < 64);
    @(negedge link_clk);
    link_req_valid = 1'b0;
    // Released lines show the inverse so a stale copy cannot pass
    link_req = ~link_req;
    n = 0;
    while (link_rsp_valid !== 1'b1 && n < 64) begin
      @(posedge link_clk);
      n++;
    end
    if (link_rsp_valid !== 1'b1) tb_top.n_mismatch++;
    r = link_rsp;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
  import psm_pkg::*;
  logic clk, rst, link_clk, link_rst, link_req_valid, link_req_ready, link_rsp_valid, link_busy;
  logic share_clk, share_present, share_run, host_alert_n_o, host_alert_n_oe, supervise_hold, nv_busy;
  logic [NCH-1:0] channel_on_pin, op_on, cur_mode, uv_reached, conv_en, dac_link, uv_unmask;
  logic [NCH-1:0][6:0] chan_fault;
  logic [7:0] unpaged_fault;
  logic [15:0] pw [2][NPW];
  logic [15:0] d, tv;
  psm_req_t link_req;
  psm_rsp_t link_rsp, r;
  int n_mismatch, compares, sc;
  psm_cmds psm_cmds_i (.clk(clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
    .link_req_valid(link_req_valid), .link_req(link_req), .link_req_ready(link_req_ready),
    .link_rsp_valid(link_rsp_valid), .link_rsp(link_rsp), .link_busy(link_busy),
    .channel_on_pin(channel_on_pin), .op_on(op_on), .share_clk(share_clk), .share_present(share_present),
    .cur_mode(cur_mode), .uv_reached(uv_reached), .chan_fault(chan_fault), .unpaged_fault(unpaged_fault),
    .conv_en(conv_en), .dac_link(dac_link), .uv_unmask(uv_unmask), .host_alert_n_o(host_alert_n_o),
    .host_alert_n_oe(host_alert_n_oe), .supervise_hold(supervise_hold), .nv_busy(nv_busy));
  psm_host psm_host_i (.link_clk(link_clk), .link_req_valid(link_req_valid), .link_req(link_req),
    .link_req_ready(link_req_ready), .link_rsp_valid(link_rsp_valid), .link_rsp(link_rsp));
  // ****************************************
  // Clocks
  // ****************************************
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // Offset keeps link edges off the core edges
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #32 link_clk = ~link_clk;
  end
  // Shared clock only runs when asked; one tick per 8 core cycles
  always @(negedge clk) begin
    sc <= sc + 1;
    if (share_run && sc % 4 == 3) share_clk <= ~share_clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] feature_exp();
    return {8'h00, 1'b1, 2'b01, 1'b1, 4'h0};
  endfunction
  function automatic logic [15:0] vexp_exp();
    return {8'h00, 3'b000, 5'h13};
  endfunction
  function automatic logic pick(input int sel, input int i);
    case (sel)
      0: return conv_en[i];
      1: return host_alert_n_oe;
      2: return nv_busy;
      default: return link_busy;
    endcase
  endfunction
  task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] v);
    psm_host_i.xfer(c, w, v, r);
    @(negedge clk);
  endtask
  task automatic wait_sig(input int sel, input int i, input logic v);
    for (int n = 0; n < 5000 && pick(sel, i) !== v; n++) @(negedge clk);
    `CHK(pick(sel, i), v)
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    link_rst = 1'b1;
    {channel_on_pin, op_on, uv_reached, chan_fault, unpaged_fault} = '0;
    {share_clk, share_run, sc, n_mismatch, compares} = '0;
    share_present = 1'b1;
    cur_mode = 8'h02;
    void'($urandom(32'h73B3));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge link_clk);
    link_rst = 1'b0;
    wait_sig(3, 0, 1'b1);
    cmd(CMD_FEATURE, 1'b0, 16'h0000);
    `CHK({r.err, r.busy}, 2'b11)
    wait_sig(2, 0, 1'b0);
    wait_sig(3, 0, 1'b0);
    cmd(CMD_FEATURE, 1'b0, 16'h0000);
    `CHK({r.rdata, r.err}, {feature_exp(), 1'b0})
    cmd(CMD_VEXP, 1'b0, 16'h0000);
    `CHK({r.rdata, r.err}, {vexp_exp(), 1'b0})
    cmd(CMD_FEATURE, 1'b1, 16'($urandom));
    `CHK(r.err, 1'b1)
    cmd(CMD_VEXP, 1'b1, 16'($urandom));
    `CHK(r.err, 1'b1)
    for (int k = 0; k < 2; k++) begin
      cmd(CMD_PAGE, 1'b1, 16'(k * 4));
      for (int s = 0; s < NPW; s++) begin
        pw[k][s] = 16'($urandom);
        cmd(PW_CODE[s], 1'b1, pw[k][s]);
      end
    end
    for (int k = 0; k < 2; k++) begin
      cmd(CMD_PAGE, 1'b1, 16'(k * 4));
      for (int s = 0; s < NPW; s++) begin
        cmd(PW_CODE[s], 1'b0, 16'h0000);
        `CHK(r.rdata, pw[k][s])
      end
    end
    for (int s = 0; s < NUW; s++) begin
      d = 16'($urandom);
      cmd(UW_CODE[s], 1'b1, d);
      cmd(UW_CODE[s], 1'b0, 16'h0000);
      `CHK(r.rdata, d)
    end
    cmd(CMD_PAGE, 1'b1, 16'h0001);
    cmd(PW_CODE[PW_OVF], 1'b1, 16'($urandom));
    `CHK(r.err, 1'b1)
    cmd(CMD_PAGE, 1'b1, 16'h0000);
    cmd(CMD_STORE, 1'b1, 16'h0000);
    wait_sig(2, 0, 1'b0);
    cmd(PW_CODE[0], 1'b1, ~pw[0][0]);
    cmd(CMD_RESTORE, 1'b1, 16'h0000);
    wait_sig(2, 0, 1'b0);
    cmd(PW_CODE[0], 1'b0, 16'h0000);
    `CHK(r.rdata, pw[0][0])
    cmd(PW_CODE[0], 1'b1, ~pw[0][0]);
    {rst, link_rst} = 2'b11;
    @(posedge link_clk);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge link_clk);
    link_rst = 1'b0;
    wait_sig(2, 0, 1'b0);
    cmd(CMD_PAGE, 1'b1, 16'h0000);
    cmd(PW_CODE[0], 1'b0, 16'h0000);
    `CHK(r.rdata, pw[0][0])
    chan_fault[0] = 7'h01;
    wait_sig(1, 0, 1'b1);
    chan_fault[0] = 7'h00;
    cmd(CMD_CLEAR, 1'b1, 16'h0000);
    `CHK(host_alert_n_oe, 1'b0)
    cmd(CMD_STATUS, 1'b0, 16'h0000);
    `CHK(r.rdata[7:0], 8'h00)
    chan_fault[0] = 7'h04;
    wait_sig(1, 0, 1'b1);
    cmd(CMD_CLEAR, 1'b1, 16'h0000);
    wait_sig(1, 0, 1'b1);
    cmd(CMD_STATUS, 1'b0, 16'h0000);
    `CHK(r.rdata[7:0], 8'h08)
    chan_fault = '0;
    chan_fault[5] = 7'h02;
    chan_fault[6] = 7'h40;
    unpaged_fault = 8'($urandom) | 8'h01;
    repeat (20) @(negedge clk);
    {chan_fault, unpaged_fault} = '0;
    cmd(CMD_PAGE, 1'b1, 16'h00FF);
    cmd(CMD_CLEAR, 1'b1, 16'h0000);
    `CHK(host_alert_n_oe, 1'b0)
    cmd(CMD_STATUS, 1'b0, 16'h0000);
    `CHK(r.rdata[7:0], 8'h00)
    for (int c = 0; c < 7; c++) begin
      cmd(CMD_PAGE, 1'b1, 16'(c));
      cmd(CMD_STATUS, 1'b0, 16'h0000);
      `CHK(r.rdata[7:0], 8'h00)
    end
    for (int c = 0; c < 3; c++) begin
      cmd(CMD_PAGE, 1'b1, 16'(c));
      for (int j = 0; j < 4; j++) begin
        tv = (j == 2 && c != 1) ? 16'h0002 : (j == 0 && c == 0) ? 16'h0001 : (j == 3 && c == 1) ? 16'hC802 : 16'h0000;
        cmd(PW_CODE[PW_TDLY + j], 1'b1, tv);
      end
    end
    uv_reached = 8'h04;
    channel_on_pin = 8'h07;
    op_on = 8'h07;
    wait_sig(0, 2, 1'b1);
    repeat (400) @(negedge clk);
    `CHK(conv_en[0], 1'b0)
    `CHK(uv_unmask[2], 1'b1)
    share_run = 1'b1;
    wait_sig(0, 0, 1'b1);
    wait_sig(0, 0, 1'b0);
    `CHK({conv_en[1], dac_link[1]}, 2'b11)
    share_present = 1'b0;
    cmd(CMD_PAGE, 1'b1, 16'h0000);
    cmd(CMD_STATUS, 1'b0, 16'h0000);
    `CHK(r.rdata[0], 1'b1)
    cmd(CMD_CLEAR, 1'b1, 16'h0000);
    repeat (100) @(negedge clk);
    `CHK(conv_en[0], 1'b0)
    channel_on_pin = 8'h00;
    op_on = 8'h00;
    wait_sig(0, 2, 1'b0);
    repeat (50) @(negedge clk);
    `CHK(conv_en[1], 1'b1)
    wait_sig(0, 1, 1'b0);
    `CHK(uv_unmask, 8'h00)
    report_and_stop();
  end
endmodule
`default_nettype wire
